// ==== src/reset_seq_pkg.sv ====
// Shared constants and types for the reset and brown-out sequencer
package reset_seq_pkg;
	// Reference clock period
	localparam int CLK_PERIOD_NS = 50;
	// Least low-supply time before a brown-out trips
	localparam int BOR_FILTER_NS = 1000;
	// Filter length in clock cycles, rounded up, at least one
	localparam int BOR_FILTER_RAW = (BOR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BOR_FILTER_CYC = (BOR_FILTER_RAW < 1) ? 1 : BOR_FILTER_RAW;
	localparam int FILTER_W = 8;
	// Power-up delay: nominal time and low-frequency oscillator rate
	localparam int POWERUP_DELAY_TIMER_MS = 64;
	localparam int LF_OSC_HZ = 31000;
	localparam int POWERUP_DELAY_TIMER_TICKS = POWERUP_DELAY_TIMER_MS * LF_OSC_HZ / 1000;
	localparam int POWERUP_DELAY_TIMER_W = 16;
	// Oscillator cycles from pin release to execution
	localparam int RELEASE_CYC = 10;
	localparam int RELEASE_W = 4;
	// Register byte addresses
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	// Control register field positions and reset value
	localparam int SW_EN_BIT = 7;
	localparam int FAST_START_BIT = 6;
	localparam int READY_BIT = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h80;
	// Status register field positions
	localparam int ST_RESET_BIT = 0;
	localparam int ST_BOR_BIT = 1;
	localparam int ST_POWERUP_DELAY_TIMER_BIT = 2;
	localparam int ST_GATE_BIT = 3;
	localparam int ST_PROT_BIT = 4;
	// Brown-out mode field codes
	localparam logic [1:0] MODE_ALWAYS_ON = 2'b11;
	localparam logic [1:0] MODE_SLEEP_OFF = 2'b10;
	localparam logic [1:0] MODE_SOFTWARE = 2'b01;
	localparam logic [1:0] MODE_ALWAYS_OFF = 2'b00;
	// Release sequence states
	typedef enum logic [2:0] {ST_HOLD, ST_WAIT, ST_RELEASE, ST_RUN} seq_state_t;
endpackage

// ==== src/brownout_filter.sv ====
// Glitch filter that trips only on a persistent low-supply indication
`timescale 1ns/100ps
`default_nettype none
module brownout_filter (
	input wire logic ref_clk_in, // Clock
	input wire logic reset_in, // Synchronous reset, high
	input wire logic low_in, // Qualified low-supply level
	output logic trip_out // Brown-out request
);
	import reset_seq_pkg::*;
	logic [FILTER_W-1:0] count_r; // Consecutive low cycles
	logic [FILTER_W-1:0] count_nxt;
	logic hit; // Persistence reached
	localparam logic [FILTER_W-1:0] LIMIT = FILTER_W'(BOR_FILTER_CYC);
	localparam logic [FILTER_W-1:0] ONE = FILTER_W'(1);
	assign hit = (count_r == LIMIT);
	// Any sample with low_in low restarts the count, so short dips never trip
	assign count_nxt = !low_in ? '0 : (hit ? count_r : count_r + ONE);
	// Counter and trip level
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			count_r <= '0;
			trip_out <= 1'b0;
		end else begin
			count_r <= count_nxt;
			trip_out <= low_in && hit;
		end
	end
endmodule
`default_nettype wire

// ==== src/powerup_timer.sv ====
// Power-up delay counter paced by the low-frequency oscillator tick
`timescale 1ns/100ps
`default_nettype none
module powerup_timer #(
	parameter int TICKS = reset_seq_pkg::POWERUP_DELAY_TIMER_TICKS // Terminal count
) (
	input wire logic ref_clk_in, // Clock
	input wire logic reset_in, // Synchronous reset, high
	input wire logic restart_in, // Cold reset source present
	input wire logic bypass_in, // Timer disabled by configuration
	input wire logic tick_in, // Low-frequency oscillator tick
	output logic done_out // Delay complete
);
	import reset_seq_pkg::*;
	logic [POWERUP_DELAY_TIMER_W-1:0] count_r; // Ticks seen since release
	logic [POWERUP_DELAY_TIMER_W-1:0] count_nxt;
	logic at_end; // Terminal count reached
	localparam logic [POWERUP_DELAY_TIMER_W-1:0] END_COUNT = POWERUP_DELAY_TIMER_W'(TICKS);
	localparam logic [POWERUP_DELAY_TIMER_W-1:0] ONE = POWERUP_DELAY_TIMER_W'(1);
	assign at_end = (count_r >= END_COUNT);
	// Held at zero while a cold source stands, so counting starts at release
	assign count_nxt = restart_in ? '0 :
		((tick_in && !at_end) ? count_r + ONE : count_r);
	// Count and completion flag
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			count_r <= '0;
			done_out <= 1'b0;
		end else begin
			count_r <= count_nxt;
			done_out <= !restart_in && (bypass_in || at_end);
		end
	end
endmodule
`default_nettype wire

// ==== src/reset_brownout_sequencer.sv ====
// Reset gathering, brown-out control and start-up release sequencer
//
// Behaviour
// - Any listed reset source forces reset
// - Power-on detector low holds reset
// - Power-up timer gives nominal 64 ms
// - Reset held while power-up timer counts
// - Timer enable bit is active low
// - Timer starts after power-on and brown-out release
// - Two-bit field selects four brown-out modes
// - Mode 11: always protected, gated start-up
// - Mode 10: off in sleep, gated wake
// - Mode 01: software enable, no start gating
// - Software mode protects once detector ready
// - Software mode protection ignores sleep
// - Brown-out needs persistent low supply
// - Forced-on modes: ready set before execution
// - Fast-start forces band-gap in modes 10, 01
// - Configuration bit selects trip level
// - Low-power request ORed into brown-out
// - Execution waits timers, pin, then 10 cycles
// - Clear pin enabled by enable or programming bit
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module reset_brownout_sequencer #(
	parameter int POWERUP_DELAY_TIMER_COUNT = reset_seq_pkg::POWERUP_DELAY_TIMER_TICKS // Power-up ticks
) (
	input wire logic ref_clk_in, // 20 MHz clock
	input wire logic reset_in, // Synchronous reset, high
	input wire logic wb_cyc_in, // Wishbone cycle
	input wire logic wb_stb_in, // Wishbone strobe
	input wire logic wb_we_in, // Wishbone write
	input wire logic [7:0] wb_adr_in, // Wishbone byte address
	input wire logic [3:0] wb_sel_in, // Wishbone byte lanes
	input wire logic [31:0] wb_dat_in, // Wishbone write data
	output logic [31:0] wb_dat_out, // Wishbone read data
	output logic wb_ack_out, // Wishbone acknowledge
	input wire logic [1:0] brownout_mode_select_in, // Mode field
	input wire logic powerup_timer_enable_n_in, // Timer enable, low
	input wire logic brownout_level_select_in, // Trip level choice
	input wire logic clear_pin_enable_in, // Clear pin enable bit
	input wire logic low_voltage_programming_in, // Programming bit
	input wire logic power_on_active_in, // Supply below minimum
	input wire logic supply_low_in, // Supply below threshold
	input wire logic detector_ready_in, // Detector ready
	input wire logic low_power_brownout_in, // Low-power request
	input wire logic master_clear_pin_n_in, // Clear pin level
	input wire logic watchdog_reset_in, // Watchdog expiry
	input wire logic reset_instr_in, // Reset instruction
	input wire logic stack_overflow_in, // Stack overflow
	input wire logic stack_underflow_in, // Stack underflow
	input wire logic prog_exit_in, // Programming mode exit
	input wire logic sleep_in, // Core in sleep
	input wire logic osc_startup_done_in, // Oscillator timer done
	input wire logic lf_tick_in, // Low-frequency clock tick
	output logic device_reset_out, // Internal reset
	output logic brownout_reset_out, // Combined brown-out
	output logic detector_enable_out, // Detector powered
	output logic bandgap_force_out, // Band-gap kept on
	output logic brownout_level_out, // Threshold select
	output logic wake_hold_out // Delay wake from sleep
);
	import reset_seq_pkg::*;

	// Control register bits
	logic sw_enable_r; // Software brown-out enable
	logic fast_start_r; // Fast-start request
	logic ready_r; // Detector ready image
	// Bus answer
	logic ack_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	// Sequencer state
	seq_state_t state_r;
	seq_state_t state_nxt;
	logic [RELEASE_W-1:0] rel_cnt_r; // Release cycle counter
	logic [RELEASE_W-1:0] rel_cnt_nxt;
	localparam logic [RELEASE_W-1:0] REL_LAST = RELEASE_W'(RELEASE_CYC - 1);
	localparam logic [RELEASE_W-1:0] REL_ONE = RELEASE_W'(1);

	// Mode decode
	wire mode_on = (brownout_mode_select_in == MODE_ALWAYS_ON);
	wire mode_sleep_off = (brownout_mode_select_in == MODE_SLEEP_OFF);
	wire mode_soft = (brownout_mode_select_in == MODE_SOFTWARE);
	wire mode_off = (brownout_mode_select_in == MODE_ALWAYS_OFF);

	// Protection active per mode
	wire prot_active = mode_on ||
		(mode_sleep_off && !sleep_in) ||
		(mode_soft && sw_enable_r);

	// Protection acts only once the detector is ready
	wire qualified_low = prot_active && detector_ready_in && supply_low_in;
	wire main_trip; // Filtered brown-out request

	brownout_filter u_filter (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.low_in(qualified_low),
		.trip_out(main_trip)
	);

	// Single brown-out request for status and power control
	wire bor_req = main_trip || low_power_brownout_in;

	// Clear pin: disabled only when both configuration bits are zero
	wire pin_enabled = clear_pin_enable_in || low_voltage_programming_in;
	wire pin_hold = pin_enabled && !master_clear_pin_n_in;

	// Cold sources restart the power-up delay; exit from programming acts as power-on
	wire cold_src = power_on_active_in || bor_req || prog_exit_in;

	// Every reset source
	wire any_src = cold_src || pin_hold || watchdog_reset_in ||
		reset_instr_in || stack_overflow_in || stack_underflow_in;

	wire powerup_delay_timer_done; // Power-up delay elapsed

	powerup_timer #(
		.TICKS(POWERUP_DELAY_TIMER_COUNT)
	) u_powerup_delay_timer (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.restart_in(cold_src),
		.bypass_in(powerup_timer_enable_n_in),
		.tick_in(lf_tick_in),
		.done_out(powerup_delay_timer_done)
	);

	// Start-up gating in forced-on modes: ready and supply above threshold
	wire startup_gate = (mode_on || mode_sleep_off) &&
		!(detector_ready_in && !supply_low_in);

	// Conditions to begin the release count
	wire release_ok = powerup_delay_timer_done && osc_startup_done_in && !startup_gate;

	// Wake from sleep waits for readiness only in mode 10
	wire wake_hold_nxt = mode_sleep_off && !detector_ready_in;

	// Band-gap forced on only in modes that honour fast start
	wire bandgap_nxt = fast_start_r && (mode_sleep_off || mode_soft);

	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		rel_cnt_nxt = rel_cnt_r;
		case (state_r)
			ST_HOLD: begin
				// Wait for every source to clear
				if (!any_src) begin
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// Timers and gating; any source, the pin included, still sends it back to hold
				if (any_src) begin
					state_nxt = ST_HOLD;
				end else if (release_ok) begin
					state_nxt = ST_RELEASE;
					rel_cnt_nxt = '0;
				end
			end
			ST_RELEASE: begin
				// Fixed oscillator cycles after the pin rises
				if (any_src) begin
					state_nxt = ST_HOLD;
				end else if (rel_cnt_r == REL_LAST) begin
					state_nxt = ST_RUN;
				end else begin
					rel_cnt_nxt = rel_cnt_r + REL_ONE;
				end
			end
			ST_RUN: begin
				// Any source drops straight back to reset
				if (any_src) begin
					state_nxt = ST_HOLD;
				end
			end
			default: begin
				state_nxt = ST_HOLD;
			end
		endcase
	end

	// Sequencer state registers
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state_r <= ST_HOLD;
			rel_cnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			rel_cnt_r <= rel_cnt_nxt;
		end
	end

	// Internal reset stands until the run state; registered so it is glitch free
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			device_reset_out <= 1'b1;
		end else begin
			device_reset_out <= (state_nxt != ST_RUN);
		end
	end

	// Power-side outputs, all registered
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			brownout_reset_out <= 1'b0;
			detector_enable_out <= 1'b0;
			bandgap_force_out <= 1'b0;
			brownout_level_out <= 1'b0;
			wake_hold_out <= 1'b0;
		end else begin
			brownout_reset_out <= bor_req;
			detector_enable_out <= prot_active;
			bandgap_force_out <= bandgap_nxt;
			brownout_level_out <= brownout_level_select_in;
			wake_hold_out <= wake_hold_nxt;
		end
	end

	// Ready image follows the detector, so it is already set in forced modes
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			ready_r <= 1'b0;
		end else begin
			ready_r <= detector_ready_in;
		end
	end

	// Bus decode; unmapped addresses answer with zero and ignore writes
	wire bus_req = wb_cyc_in && wb_stb_in;
	// Read data is loaded only with the answer, so the port needs no output mux
	wire load_rdata = bus_req && !ack_r;
	wire hit_control = (wb_adr_in == ADDR_CONTROL);
	wire hit_status = (wb_adr_in == ADDR_STATUS);
	// Write lands at the edge where the master sees ack high
	wire wr_fire = bus_req && wb_we_in && ack_r && wb_sel_in[0];
	wire wr_control = wr_fire && hit_control;

	// Read images; reserved bits read as zero
	wire [31:0] control_img = {24'h00_0000, sw_enable_r, fast_start_r, 5'b0_0000, ready_r};
	wire [31:0] status_img = {27'h000_0000, prot_active, startup_gate,
		!powerup_delay_timer_done, brownout_reset_out, device_reset_out};

	// Read data select
	always_comb begin
		if (hit_control) begin
			rdata_nxt = control_img;
		end else if (hit_status) begin
			rdata_nxt = status_img;
		end else begin
			rdata_nxt = 32'h0000_0000;
		end
	end

	// Single-wait acknowledge, dropped the cycle after it is given
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= load_rdata;
			// Zero outside the acknowledge cycle
			rdata_r <= load_rdata ? rdata_nxt : 32'h0000_0000;
		end
	end

	// Control bits are writable in every mode; their effect depends on mode
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			sw_enable_r <= CONTROL_RESET[SW_EN_BIT];
			fast_start_r <= CONTROL_RESET[FAST_START_BIT];
		end else if (wr_control) begin
			sw_enable_r <= wb_dat_in[SW_EN_BIT];
			fast_start_r <= wb_dat_in[FAST_START_BIT];
		end
	end

	assign wb_ack_out = ack_r;
	assign wb_dat_out = rdata_r;

	// Helper for the release check: edges since a reset source was last seen
	localparam logic [7:0] QUIET_MAX = 8'hff;
	localparam logic [7:0] QUIET_ONE = 8'h01;
	localparam logic [7:0] QUIET_MIN = 8'(RELEASE_CYC + 2);
	logic [7:0] quiet_r; // Quiet edge count, saturating
	logic [7:0] quiet_nxt;
	// Saturates so a long run never wraps back into the early window
	assign quiet_nxt = any_src ? '0 : ((quiet_r == QUIET_MAX) ? quiet_r : quiet_r + QUIET_ONE);
	// Helper counter register
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			quiet_r <= '0;
		end else begin
			quiet_r <= quiet_nxt;
		end
	end

	// Checks
	AST_SOURCE_HOLDS_RESET: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(any_src |=> device_reset_out))
		else $error("reset source did not hold internal reset");

	AST_POR_HOLD: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(power_on_active_in |=> device_reset_out))
		else $error("reset released during power-on");

	AST_POWERUP_DELAY_TIMER_HOLD: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(!powerup_delay_timer_done && !$past(powerup_delay_timer_done) |-> device_reset_out))
		else $error("reset released while delay counting");

	AST_POWERUP_DELAY_TIMER_RESTART: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(cold_src |=> !powerup_delay_timer_done))
		else $error("delay done while cold source present");

	AST_BYPASS: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(powerup_timer_enable_n_in && !cold_src && $stable(powerup_timer_enable_n_in)
		|=> powerup_delay_timer_done))
		else $error("bypassed delay not complete");

	AST_RELEASE_TEN: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(state_r == ST_RELEASE && rel_cnt_r == REL_LAST && !any_src |=> !device_reset_out))
		else $error("execution did not begin after the release count");

	// Hold, wait, then the full release count must all pass quietly
	AST_NO_EARLY_RUN: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		($fell(device_reset_out) |-> quiet_r >= QUIET_MIN))
		else $error("execution began early");

	AST_MODE_OFF: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(mode_off |-> !prot_active && !startup_gate))
		else $error("protection active in off mode");

	AST_SOFT_SLEEP: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(mode_soft && $stable(brownout_mode_select_in) && $stable(sw_enable_r) && $changed(sleep_in)
		|-> prot_active == $past(prot_active)))
		else $error("sleep changed protection in software mode");

	AST_GLITCH_REJECT: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		($rose(qualified_low) |=> !main_trip [*8]))
		else $error("short dip tripped brown-out");

	AST_LP_OR: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(low_power_brownout_in |=> brownout_reset_out))
		else $error("low-power request not merged");

	AST_FAST_START: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		((mode_on || mode_off) |=> !bandgap_force_out))
		else $error("fast start honoured in forced mode");

	AST_PIN_DISABLED: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(!clear_pin_enable_in && !low_voltage_programming_in |-> !pin_hold))
		else $error("disabled clear pin held reset");
endmodule
`default_nettype wire

// ==== tb/reset_brownout_sequencer_tb.sv ====
// Self-checking bench for the reset and brown-out sequencer
`timescale 1ns/100ps
`default_nettype none
module reset_brownout_sequencer_tb;
	import reset_seq_pkg::*;
	localparam int POWERUP_DELAY_TIMER_N = 4; // Shortened power-up count keeps the run brief
	localparam int TICK = 8; // Clock cycles per low-frequency tick
	logic clk, rst, cyc, stb, we, ack, ten_n, lvl, cpe, low_voltage_programming, pon, sup_low, rdy, lpb, slp;
	logic lf_tick = 1'b0; // Low-frequency tick, one driver only
	logic dev_rst, bor_out, det_en, bgf, lvl_out, wake_hold;
	logic [1:0] mode; // Brown-out mode field
	logic [5:0] warm; // Warm sources plus programming exit at bit 4, bit 5 pulls the clear pin low
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, rdat, q;
	logic [2:0] tdiv = 3'h0; // Tick divider
	int miscompares = 0;
	int compares = 0;
	int n;
	reset_brownout_sequencer #(.POWERUP_DELAY_TIMER_COUNT(POWERUP_DELAY_TIMER_N)) DUT (.ref_clk_in(clk), .reset_in(rst),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
		.wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack), .brownout_mode_select_in(mode),
		.powerup_timer_enable_n_in(ten_n), .brownout_level_select_in(lvl),
		.clear_pin_enable_in(cpe), .low_voltage_programming_in(low_voltage_programming), .power_on_active_in(pon),
		.supply_low_in(sup_low), .detector_ready_in(rdy), .low_power_brownout_in(lpb),
		.master_clear_pin_n_in(~warm[5]), .watchdog_reset_in(warm[0]),
		.reset_instr_in(warm[1]), .stack_overflow_in(warm[2]), .stack_underflow_in(warm[3]),
		.prog_exit_in(warm[4]), .sleep_in(slp), .osc_startup_done_in(1'b1),
		.lf_tick_in(lf_tick), .device_reset_out(dev_rst), .brownout_reset_out(bor_out),
		.detector_enable_out(det_en), .bandgap_force_out(bgf), .brownout_level_out(lvl_out),
		.wake_hold_out(wake_hold));
	// Clock generator, 50 ns period
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	// Low-frequency tick, one cycle in every eight
	always @(posedge clk) begin
		tdiv <= tdiv + 3'h1;
		lf_tick <= (tdiv == 3'h7);
	end
	// Compare one value and count it
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Classic Wishbone single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		q = rdat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		@(posedge clk);
	endtask
	// Count cycles until internal reset drops; the watchdog cuts a hang
	task automatic wait_low();
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (dev_rst !== 1'b0);
	endtask
	// Pulse one warm source for a cycle, then check that reset is held
	task automatic pulse(input logic [5:0] s);
		warm <= s;
		@(posedge clk);
		warm <= 6'h00;
		repeat (3) @(posedge clk);
		check(dev_rst, 1'b1);
	endtask
	// Power-on release with the delay bypassed, then register reset values
	task automatic t_power_on();
		pon <= 0;
		wait_low();
		check(n >= 11 && n <= 16, 1'b1);
		wb(0, ADDR_CONTROL, 32'h0000_0000);
		check(q, 32'h0000_0081);
		wb(0, ADDR_STATUS, 32'h0000_0000);
		check(q[ST_RESET_BIT], 1'b0);
		$display("power-on test done");
	endtask
	// Delay timer enabled: reset lasts its whole count
	task automatic t_delay();
		ten_n <= 0;
		pon <= 1;
		repeat (5) @(posedge clk);
		check(dev_rst, 1'b1);
		pon <= 0;
		wait_low();
		check(n >= (POWERUP_DELAY_TIMER_N - 1) * TICK + 10, 1'b1);
		check(n <= (POWERUP_DELAY_TIMER_N + 1) * TICK + 16, 1'b1);
		ten_n <= 1;
		$display("delay test done");
	endtask
	// Every warm source and programming exit, then clear pin enable decoding
	task automatic t_sources();
		for (int i = 0; i < 6; i++) begin
			pulse(6'h01 << i);
			wait_low();
			check(n <= 16, 1'b1);
		end
		cpe <= 0;
		warm <= 6'h20;
		repeat (5) @(posedge clk);
		check(dev_rst, 1'b0);
		low_voltage_programming <= 1;
		repeat (25) @(posedge clk);
		check(dev_rst, 1'b1);
		warm <= 6'h00;
		wait_low();
		check(n >= 10 && n <= 14, 1'b1);
		low_voltage_programming <= 0;
		cpe <= 1;
		$display("source test done");
	endtask
	// Short dips are rejected, long ones and low-power requests trip
	task automatic t_filter();
		sup_low <= 1;
		repeat (15) @(posedge clk);
		sup_low <= 0;
		repeat (3) @(posedge clk);
		check(bor_out, 1'b0);
		check(dev_rst, 1'b0);
		sup_low <= 1;
		repeat (25) @(posedge clk);
		check(bor_out, 1'b1);
		check(dev_rst, 1'b1);
		sup_low <= 0;
		wait_low();
		lpb <= 1;
		repeat (3) @(posedge clk);
		check(bor_out, 1'b1);
		lpb <= 0;
		wait_low();
		$display("filter test done");
	endtask
	// Mode table against software enable and sleep, then start-up gating
	task automatic t_modes();
		for (int e = 0; e < 2; e++) begin
			wb(1, ADDR_CONTROL, e ? 32'h0000_00c0 : 32'h0000_0040);
			for (int m = 0; m < 4; m++) begin
				for (int s = 0; s < 2; s++) begin
					mode <= m[1:0];
					slp <= s[0];
					repeat (3) @(posedge clk);
					check(det_en, m == 3 || (m == 2 && s == 0) || (m == 1 && e == 1));
					check(bgf, m == 1 || m == 2);
				end
			end
		end
		slp <= 0;
		mode <= 2'b10;
		rdy <= 0;
		repeat (3) @(posedge clk);
		check(wake_hold, 1'b1);
		wb(0, ADDR_CONTROL, 32'h0000_0000);
		check(q, 32'h0000_00c0);
		pulse(6'h01);
		repeat (30) @(posedge clk);
		check(dev_rst, 1'b1);
		rdy <= 1;
		wait_low();
		check(wake_hold, 1'b0);
		mode <= 2'b01;
		rdy <= 0;
		pulse(6'h01);
		wait_low();
		check(n <= 16, 1'b1);
		rdy <= 1;
		lvl <= 1;
		repeat (3) @(posedge clk);
		check(lvl_out, 1'b1);
		$display("mode test done");
	endtask
	// Unmapped place reads zero and ignores writes
	task automatic t_unmapped();
		wb(1, 8'h08, 32'h0000_00ff);
		wb(0, 8'h08, 32'h0000_0000);
		check(q, 32'h0000_0000);
		// Write with the low lane off must be ignored
		sel <= 4'h0;
		wb(1, ADDR_CONTROL, 32'h0000_0000);
		sel <= 4'h1;
		wb(0, ADDR_STATUS, 32'h0000_0000);
		check(q, 32'h0000_0010);
		wb(0, ADDR_CONTROL, 32'h0000_0000);
		check(q, 32'h0000_00c1);
		$display("unmapped test done");
	endtask
	// Counts and verdict, the single end of the run
	task automatic end_of_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog sized well above the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
	// Main sequence
	initial begin
		rst = 1; cyc = 0; stb = 0; we = 0; adr = 8'h00; sel = 4'h1; dat = 32'h0000_0000;
		ten_n = 1; lvl = 0; cpe = 1; low_voltage_programming = 0; pon = 1; sup_low = 0; rdy = 1; lpb = 0;
		slp = 0; mode = 2'b11; warm = 6'h00;
		repeat (3) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		t_power_on();
		t_delay();
		t_sources();
		t_filter();
		t_modes();
		t_unmapped();
		end_of_test();
	end
endmodule
`default_nettype wire
